// ---- logic/pvt_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module pvt_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic             push;
  logic             pop;

  always_comb
  begin
    in_ready    = (count != (AW+1)'(DEPTH));
    out_valid   = (count != '0);
    out_data    = mem[rd_ptr];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      count  <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      count  <= next_count;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
endmodule // pvt_fifo

// ---- logic/pvt_link_if.sv ----
// link between video source and panel: video stream, hpd, power, backlight
`timescale 1ns/100ps
interface pvt_link_if
  import pvt_pkg::*;
();
  logic       panel_power;
  logic       hot_plug;
  logic       video_valid;
  logic       active_video_window;
  logic       line_start;
  logic       frame_start;
  pvt_pixel_t pixel;
  logic       backlight_supply;
  logic       backlight_dimming_signal;
  logic       backlight_enable;
  modport source (
    output panel_power, video_valid, active_video_window, line_start,
    output frame_start, pixel, backlight_supply,
    output backlight_dimming_signal, backlight_enable,
    input  hot_plug
  );
  modport panel (
    input  panel_power, video_valid, active_video_window, line_start,
    input  frame_start, pixel, backlight_supply,
    input  backlight_dimming_signal, backlight_enable,
    output hot_plug
  );
endinterface

// ---- logic/pvt_panel.sv ----
// panel end: hot plug, black video, captures and shows valid video
`timescale 1ns/100ps
module pvt_panel
  import pvt_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // shown pixel out
  output      logic       show_valid,
  output      pvt_pixel_t show_pixel,
  output      logic       show_line_start,
  output      logic       show_frame_start,
  output      logic       backlight_lit,
  // link
  pvt_link_if.panel       link
);
  logic [2:0] pwr_sync;
  logic       pwr;
  logic       next_pwr;
  logic       out_hpd;
  logic       next_hpd;
  logic       out_valid;
  logic       next_valid;
  pvt_pixel_t out_pix;
  pvt_pixel_t next_pix;
  logic       out_ls;
  logic       next_ls;
  logic       out_fs;
  logic       next_fs;
  logic       out_lit;
  logic       next_lit;

  // power passes three stages; change on 2nd/3rd agree
  // video qualifiers share the clock, so no lag cuts line 0
  always_comb
  begin
    next_pwr   = (pwr_sync[2] == pwr_sync[1]) ? pwr_sync[1] : pwr;
    next_hpd   = next_pwr;
    next_valid = next_pwr;
    next_pix   = PIX_BLACK;
    next_ls    = 1'b0;
    next_fs    = 1'b0;
    if (next_pwr && link.video_valid && link.active_video_window)
      next_pix = link.pixel;
    if (next_pwr && link.video_valid)
    begin
      next_ls = link.line_start;
      next_fs = link.frame_start;
    end
    next_lit = link.backlight_enable && link.backlight_supply
            && link.backlight_dimming_signal;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pwr_sync  <= 3'h0;
      pwr       <= 1'b0;
      out_hpd   <= 1'b0;
      out_valid <= 1'b0;
      out_pix   <= PIX_BLACK;
      out_ls    <= 1'b0;
      out_fs    <= 1'b0;
      out_lit   <= 1'b0;
    end
    else
    begin
      pwr_sync  <= {pwr_sync[1:0], link.panel_power};
      pwr       <= next_pwr;
      out_hpd   <= next_hpd;
      out_valid <= next_valid;
      out_pix   <= next_pix;
      out_ls    <= next_ls;
      out_fs    <= next_fs;
      out_lit   <= next_lit;
    end
  end

  assign link.hot_plug    = out_hpd;
  assign show_valid       = out_valid;
  assign show_pixel       = out_pix;
  assign show_line_start  = out_ls;
  assign show_frame_start = out_fs;
  assign backlight_lit    = out_lit;
endmodule // pvt_panel

// ---- logic/pvt_pkg.sv ----
// shared constants and types for the panel video timing and power sequencer
package pvt_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned CHAN_BITS       = 6;
  localparam int unsigned PIX_BITS        = 3 * CHAN_BITS;
  localparam int unsigned RED_MSB         = 17;
  localparam int unsigned GREEN_MSB       = 11;
  localparam int unsigned BLUE_MSB        = 5;
  localparam int unsigned LINE_ACTIVE_CLOCKS = 1920;
  localparam int unsigned LINE_TOTAL_CLOCKS  = 2250;
  localparam int unsigned LINE_BLANK_CLOCKS  =
    LINE_TOTAL_CLOCKS - LINE_ACTIVE_CLOCKS;
  localparam int unsigned FRAME_ACTIVE_LINES = 1080;
  localparam int unsigned FRAME_TOTAL_LINES  = 1132;
  localparam int unsigned FRAME_BLANK_LINES  =
    FRAME_TOTAL_LINES - FRAME_ACTIVE_LINES;
  localparam real PIXEL_CLOCK_MHZ = 76.41;
  localparam int unsigned HPD_MAX_MS      = 200;
  localparam int unsigned BLACK_MAX_MS    = 200;
  localparam int unsigned SHOW_MAX_MS     = 50;
  localparam int unsigned OFF_MAX_MS      = 500;
  localparam int unsigned SUPPLY_OFF_HOLD_MS = 500;
  localparam int unsigned BL_STEP_MS      = 1;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned HPD_MAX_CYC     = HPD_MAX_MS * CYC_PER_MS;
  localparam int unsigned SHOW_MAX_CYC    = SHOW_MAX_MS * CYC_PER_MS;
  localparam int unsigned OFF_MAX_CYC     = OFF_MAX_MS * CYC_PER_MS;
  localparam int unsigned HOLD_MIN_CYC    = SUPPLY_OFF_HOLD_MS * CYC_PER_MS;
  localparam int unsigned BL_STEP_CYC     = BL_STEP_MS * CYC_PER_MS;
  localparam int unsigned FIFO_DEPTH      = 16;
  localparam logic [PIX_BITS-1:0] PIX_BLACK = 18'h0_0000;
  typedef logic [PIX_BITS-1:0] pvt_pixel_t;
endpackage

// ---- logic/pvt_source.sv ----
// video source end: power sequencer, timing generator, backlight control
// What the link requires of source and panel
// - each colour channel is six bits
// - larger channel code means brighter colour
// - pixel word packs red, green, blue, msb first
// - data bit one is high level
// - pixel rate nominally 76.41 MHz; here one pixel per clk, with CLK_HZ at 40 MHz
// - active window spans 1920 clocks per line
// - line total 2250, blanking 330 clocks
// - each frame has 1080 active lines
// - frame total 1132, blanking 52 lines
// - panel raises hot plug within 200 ms
// - panel makes black video within 200 ms
// - train link after hot plug, then video
// - panel shows valid video within 50 ms
// - backlight on only after valid video
// - backlight off before video stops
// - power off within 500 ms, stay off 500 ms
// - supply up 1 ms before dimming signal
// - dimming 1 ms before backlight enable
// - dimming stays 1 ms after enable drops
// - dimming off 1 ms before supply falls
// - no floating or invalid signalling
// - backlight after logic power and video
// - enable gates converter, dimming sets brightness
`timescale 1ns/100ps
module pvt_source
  import pvt_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // user control
  input  wire logic       power_request,
  input  wire logic       dimming_level,
  // pixel stream in
  input  wire logic       pix_valid,
  output      logic       pix_ready,
  input  wire pvt_pixel_t pix_data,
  // status
  output      logic       running,
  // link
  pvt_link_if.source      link
);
  typedef enum {
    S_OFF, S_WAIT_HPD, S_TRAIN, S_VIDEO, S_BL_SUP, S_BL_DIM, S_BL_ON,
    S_BLD_EN, S_BLD_DIM, S_BLD_SUP, S_VID_END, S_HOLD
  } pvt_state_t;

  pvt_state_t  state;
  pvt_state_t  next_state;
  logic [24:0] timer;
  logic [24:0] next_timer;
  logic [2:0]  hpd_sync;
  logic        hpd_seen;
  logic        next_hpd_seen;
  logic [11:0] hcount;
  logic [11:0] next_hcount;
  logic [10:0] vcount;
  logic [10:0] next_vcount;
  logic        fifo_valid;
  pvt_pixel_t  fifo_data;
  logic        active;
  logic        out_power;
  logic        out_video;
  logic        out_de;
  logic        out_ls;
  logic        out_fs;
  pvt_pixel_t  out_pix;
  logic        out_sup;
  logic        out_dim;
  logic        out_en;
  logic        out_run;
  logic        n_power;
  logic        n_video;
  logic        n_de;
  logic        n_ls;
  logic        n_fs;
  pvt_pixel_t  n_pix;
  logic        n_sup;
  logic        n_dim;
  logic        n_en;
  logic        n_run;

  pvt_fifo #(.WIDTH(PIX_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .in_data   (pix_data),
    .out_valid (fifo_valid),
    .out_ready (n_de),
    .out_data  (fifo_data)
  );

  // hot plug from the other end is asynchronous: three stages
  always_ff @(posedge clk)
  begin
    if (!rstn)
      hpd_sync <= 3'h0;
    else
      hpd_sync <= {hpd_sync[1:0], link.hot_plug};
  end

  always_comb
  begin
    next_hpd_seen = hpd_seen;
    if (hpd_sync[2] == hpd_sync[1])
      next_hpd_seen = hpd_sync[1];
  end

  // sequencer: timed waits counted on clk; the wait for hot plug has no limit
  always_comb
  begin
    next_state = state;
    next_timer = (timer != '0) ? timer - 1'b1 : timer;
    unique case (state)
      S_OFF:
        if (power_request)
        begin
          next_state = S_WAIT_HPD;
        end
      S_WAIT_HPD:
        if (hpd_seen)
        begin
          next_state = S_TRAIN;
          next_timer = 25'(BL_STEP_CYC);
        end
      S_TRAIN:
        if (timer == '0)
        begin
          next_state = S_VIDEO;
          next_timer = 25'(SHOW_MAX_CYC);
        end
      S_VIDEO:
        if (!power_request)
          next_state = S_VID_END;
        else if (timer == '0)
        begin
          next_state = S_BL_SUP;
          next_timer = 25'(BL_STEP_CYC);
        end
      S_BL_SUP:
        if (timer == '0)
        begin
          next_state = S_BL_DIM;
          next_timer = 25'(BL_STEP_CYC);
        end
      S_BL_DIM:
        if (timer == '0)
          next_state = S_BL_ON;
      S_BL_ON:
        if (!power_request || !hpd_seen)
        begin
          next_state = S_BLD_EN;
          next_timer = 25'(BL_STEP_CYC);
        end
      S_BLD_EN:
        if (timer == '0)
        begin
          next_state = S_BLD_DIM;
          next_timer = 25'(BL_STEP_CYC);
        end
      S_BLD_DIM:
        if (timer == '0)
          next_state = S_BLD_SUP;
      S_BLD_SUP:
        next_state = S_VID_END;
      S_VID_END:
      begin
        next_state = S_HOLD;
        next_timer = 25'(HOLD_MIN_CYC);
      end
      S_HOLD:
        if (timer == '0)
          next_state = S_OFF;
    endcase
  end

  // raster counters: 2250 x 1132 with 1920 x 1080 active
  always_comb
  begin
    next_hcount = hcount;
    next_vcount = vcount;
    // held at zero until video is on the link, so line 0 is full length
    if (!out_video)
    begin
      next_hcount = '0;
      next_vcount = '0;
    end
    else if (hcount == 12'(LINE_TOTAL_CLOCKS - 1))
    begin
      next_hcount = '0;
      next_vcount = (vcount == 11'(FRAME_TOTAL_LINES - 1)) ? '0
                  : vcount + 1'b1;
    end
    else
      next_hcount = hcount + 1'b1;
    active = out_video && (hcount < 12'(LINE_ACTIVE_CLOCKS))
          && (vcount < 11'(FRAME_ACTIVE_LINES));
  end

  // outputs derived from state; video drives black until fifo has data
  always_comb
  begin
    n_power = (state != S_OFF) && (state != S_HOLD);
    n_video = (state == S_VIDEO) || (state == S_BL_SUP)
           || (state == S_BL_DIM) || (state == S_BL_ON)
           || (state == S_BLD_EN) || (state == S_BLD_DIM)
           || (state == S_BLD_SUP);
    n_sup   = (state == S_BL_SUP) || (state == S_BL_DIM)
           || (state == S_BL_ON) || (state == S_BLD_EN)
           || (state == S_BLD_DIM);
    n_dim   = ((state == S_BL_DIM) || (state == S_BL_ON)
           || (state == S_BLD_EN)) && dimming_level;
    n_en    = (state == S_BL_ON);
    n_run   = (state == S_BL_ON);
    // window and starts drop together with video_valid
    n_de    = active && n_video;
    n_ls    = out_video && n_video && (hcount == '0);
    n_fs    = out_video && n_video && (hcount == '0) && (vcount == '0);
    n_pix   = (n_de && fifo_valid) ? fifo_data : PIX_BLACK;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state     <= S_OFF;
      timer     <= '0;
      hpd_seen  <= 1'b0;
      hcount    <= '0;
      vcount    <= '0;
      out_power <= 1'b0;
      out_video <= 1'b0;
      out_de    <= 1'b0;
      out_ls    <= 1'b0;
      out_fs    <= 1'b0;
      out_pix   <= PIX_BLACK;
      out_sup   <= 1'b0;
      out_dim   <= 1'b0;
      out_en    <= 1'b0;
      out_run   <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      timer     <= next_timer;
      hpd_seen  <= next_hpd_seen;
      hcount    <= next_hcount;
      vcount    <= next_vcount;
      out_power <= n_power;
      out_video <= n_video;
      out_de    <= n_de;
      out_ls    <= n_ls;
      out_fs    <= n_fs;
      out_pix   <= n_pix;
      out_sup   <= n_sup;
      out_dim   <= n_dim;
      out_en    <= n_en;
      out_run   <= n_run;
    end
  end

  assign link.panel_power              = out_power;
  assign link.video_valid              = out_video;
  assign link.active_video_window      = out_de;
  assign link.line_start               = out_ls;
  assign link.frame_start              = out_fs;
  assign link.pixel                    = out_pix;
  assign link.backlight_supply         = out_sup;
  assign link.backlight_dimming_signal = out_dim;
  assign link.backlight_enable         = out_en;
  assign running                       = out_run;
endmodule // pvt_source

// ---- tb/panel_video_timing_power_seq_test.sv ----
// self-checking bench: source and panel joined by the link
`timescale 1ns/100ps
module panel_video_timing_power_seq_test;
  import pvt_pkg::*;

  localparam int LIMIT = 80000;
  // r g b packed msb first
  localparam pvt_pixel_t PAT [16] = '{
    18'h3_F000, 18'h0_0FC0, 18'h0_003F, 18'h3_FFFF,
    18'h0_1000, 18'h0_0040, 18'h0_0001, 18'h3_E000,
    18'h0_F000, 18'h0_0F80, 18'h0_003E, 18'h3_F03F,
    18'h3_FFC0, 18'h0_0FFF, 18'h2_0820, 18'h1_0410};

  logic       clk;
  logic       rstn;
  logic       power_request;
  logic       dimming_level;
  logic       pix_valid;
  logic       pix_ready;
  pvt_pixel_t pix_data;
  logic       running;
  logic       show_valid;
  pvt_pixel_t show_pixel;
  logic       show_line_start;
  logic       show_frame_start;
  logic       backlight_lit;
  int         miscompares = 0;
  int         checks_done = 0;
  int         cycles = 0;
  int         n;

  pvt_link_if pvt_link_if_i ();
  pvt_source pvt_source_i (
    .clk(clk), .rstn(rstn), .power_request(power_request),
    .dimming_level(dimming_level), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_data(pix_data), .running(running),
    .link(pvt_link_if_i.source));
  pvt_panel pvt_panel_i (
    .clk(clk), .rstn(rstn), .show_valid(show_valid),
    .show_pixel(show_pixel), .show_line_start(show_line_start),
    .show_frame_start(show_frame_start),
    .backlight_lit(backlight_lit), .link(pvt_link_if_i.panel));
  pvt_link_monitor pvt_link_monitor_i (
    .clk(clk), .rstn(rstn),
    .panel_power(pvt_link_if_i.panel_power),
    .hot_plug(pvt_link_if_i.hot_plug),
    .video_valid(pvt_link_if_i.video_valid),
    .active_video_window(pvt_link_if_i.active_video_window),
    .line_start(pvt_link_if_i.line_start),
    .frame_start(pvt_link_if_i.frame_start),
    .backlight_supply(pvt_link_if_i.backlight_supply),
    .backlight_dimming_signal(pvt_link_if_i.backlight_dimming_signal),
    .backlight_enable(pvt_link_if_i.backlight_enable));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      $display("[FAIL] %0t timeout", $time);
      finish_test();
    end
  end

  task automatic tick();
    @(posedge clk);
    #2;
  endtask

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  function automatic logic sel(input int k);
    case (k)
      0: return pvt_link_if_i.panel_power;
      1: return pvt_link_if_i.hot_plug;
      2: return pvt_link_if_i.video_valid;
      3: return pvt_link_if_i.line_start;
      default: return show_pixel !== PIX_BLACK;
    endcase
  endfunction

  // bounded wait for a level, n counts cycles spent
  task automatic wait_sig(input int k, input logic v, input int lim,
                          output int cnt);
    cnt = 0;
    while (sel(k) !== v && cnt < lim)
    begin
      tick();
      cnt++;
    end
  endtask

  task automatic t_reset();
    check(!(sel(0) | sel(1) | sel(2) | show_valid | running), "idle");
    check(show_pixel === PIX_BLACK, "idle pixel");
  endtask

  // fill the fifo until it refuses
  task automatic t_fill();
    n = 0;
    pix_valid = 1'b1;
    repeat (20)
    begin
      pix_data = PAT[n[3:0]];
      if (pix_ready === 1'b1)
        n++;
      tick();
    end
    pix_valid = 1'b0;
    check(n == FIFO_DEPTH && pix_ready === 1'b0, "fifo depth");
  endtask

  task automatic t_power_up();
    power_request = 1'b1;
    wait_sig(0, 1'b1, 4, n);
    check(n < 4, "power late");
    wait_sig(1, 1'b1, 12, n);
    check(n < 12, "hot plug late");
    check(show_valid && show_pixel === PIX_BLACK, "no black");
    wait_sig(2, 1'b1, BL_STEP_CYC + 20, n);
    check(n >= BL_STEP_CYC && n < BL_STEP_CYC + 20, "video start");
    check(sel(1) && !running && !backlight_lit, "bl early");
  endtask

  task automatic t_show();
    wait_sig(4, 1'b1, 3 * LINE_TOTAL_CLOCKS, n);
    check(n < 3 * LINE_TOTAL_CLOCKS, "no video");
    check(show_frame_start === 1'b1 && show_line_start === 1'b1, "frame start");
    for (int i = 0; i < 16; i++)
    begin
      check(show_pixel === PAT[i], "pixel word");
      tick();
    end
    check(show_pixel === PIX_BLACK, "underflow");
  endtask

  task automatic t_line();
    int d;
    d = 0;
    wait_sig(3, 1'b1, 2 * LINE_TOTAL_CLOCKS, n);
    n = 0;
    do
    begin
      tick();
      n++;
      d += pvt_link_if_i.active_video_window;
    end
    while (sel(3) !== 1'b1 && n < 3000);
    check(n == LINE_TOTAL_CLOCKS, "line total");
    check(d == LINE_ACTIVE_CLOCKS, "active clocks");
    tick();
    check(show_line_start === 1'b1, "line start shown");
  endtask

  task automatic t_shutdown();
    power_request = 1'b0;
    wait_sig(2, 1'b0, 20, n);
    check(n < 20 && sel(0), "video stop");
    tick();
    check(sel(0) === 1'b0, "power not off");
    repeat (12) tick();
    check(!(sel(1) | show_valid), "panel up");
    check(!(backlight_lit | running), "lit");
    power_request = 1'b1;
    repeat (1000) tick();
    check(sel(0) === 1'b0, "early repower");
    power_request = 1'b0;
  endtask

  initial
  begin
    rstn = 1'b0;
    power_request = 1'b0;
    dimming_level = 1'b1;
    pix_valid = 1'b0;
    pix_data = PIX_BLACK;
    repeat (5) tick();
    rstn = 1'b1;
    t_reset();
    t_fill();
    t_power_up();
    t_show();
    t_line();
    t_shutdown();
    finish_test();
  end
endmodule // panel_video_timing_power_seq_test

// ---- tb/pvt_link_monitor.sv ----
// assertions on the source to panel link
`timescale 1ns/100ps
module pvt_link_monitor
  import pvt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link signals
  input wire logic panel_power,
  input wire logic hot_plug,
  input wire logic video_valid,
  input wire logic active_video_window,
  input wire logic line_start,
  input wire logic frame_start,
  input wire logic backlight_supply,
  input wire logic backlight_dimming_signal,
  input wire logic backlight_enable
);
  logic [11:0] de_run, next_de_run;
  logic [11:0] gap, next_gap;
  logic        seen, next_seen;
  logic [2:0]  bl, prev_bl;
  logic [15:0] age, next_age;

  assign bl = {backlight_supply, backlight_dimming_signal, backlight_enable};

  // run lengths of window, line and backlight steps
  always_comb
  begin
    next_de_run = active_video_window ? de_run + 12'h001 : 12'h000;
    next_gap    = line_start ? 12'h001 : gap + {11'h000, gap != 12'hFFF};
    next_seen   = video_valid && (seen || line_start);
    next_age    = (bl != prev_bl) ? 16'h0001 :
                  age + {15'h0000, age != 16'hFFFF};
  end

  always_ff @(posedge clk)
  begin
    de_run  <= rstn ? next_de_run : 12'h000;
    gap     <= rstn ? next_gap : 12'h000;
    seen    <= rstn && next_seen;
    prev_bl <= rstn ? bl : 3'h0;
    age     <= rstn ? next_age : 16'h0000;
  end

  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_hpd_after_power: assert property (
    $rose(panel_power) |-> ##[1:12] hot_plug)
    else $error("hot plug late");
  a_video_after_hpd: assert property (
    $rose(video_valid) |-> hot_plug && panel_power)
    else $error("video before hot plug");
  a_window_in_video: assert property (
    active_video_window |-> video_valid)
    else $error("window outside video");
  a_line_active_len: assert property (
    $fell(active_video_window) && video_valid
      |-> de_run == LINE_ACTIVE_CLOCKS)
    else $error("active window length");
  a_line_total_len: assert property (
    line_start && seen |-> gap == LINE_TOTAL_CLOCKS)
    else $error("line total length");
  a_frame_on_line: assert property (
    frame_start |-> line_start)
    else $error("frame start off line");
  a_bl_needs_video: assert property (
    backlight_supply |-> video_valid && panel_power)
    else $error("backlight without video");
  a_en_needs_all: assert property (
    backlight_enable |-> backlight_supply && backlight_dimming_signal)
    else $error("enable without supply");
  a_bl_step_gap: assert property (
    bl != prev_bl && prev_bl != 3'h0 && prev_bl != 3'h7
      |-> age >= BL_STEP_CYC)
    else $error("backlight step too soon");
  a_power_after_video: assert property (
    $fell(video_valid) |=> !panel_power)
    else $error("power kept after video");

  c_video_up: cover property ($rose(video_valid));
  c_line_done: cover property (line_start && seen);
  c_hpd_up: cover property ($rose(hot_plug));
endmodule // pvt_link_monitor
